// ### verilog/tssp_top.v
`timescale 1ns/1ns
`default_nettype none
`include "tssp_map.vh"
////////////////////////////////////////////////////////////////////////////////
module tssp_top (
  // Clock and reset
  input  wire        REF_CLK,
  input  wire        RST,
  // AHB-Lite slave
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output wire [31:0] HRDATA,
  output wire        HREADYOUT,
  output wire        HRESP,
  // Analog front end
  input  wire        MOD_BIT,
  output wire        MOD_IDAC_ON,
  output wire [7:0]  SENSE_SEL,
  output wire        SCAN_ACTIVE,
  // Results
  output wire [7:0]  SENSOR_ON,
  output wire        IRQ
);

  localparam S_IDLE = 2'h0;
  localparam S_CHK  = 2'h1;
  localparam S_SCAN = 2'h2;
  localparam S_PROC = 2'h3;

  function [3:0] popc;
    input [7:0] v;
    integer k;
    begin
      popc = 4'h0;
      for (k = 0; k < 8; k = k + 1)
        popc = popc + {3'h0, v[k]};
    end
  endfunction

  function [2:0] enc;
    input [7:0] v;
    integer k;
    begin
      enc = 3'h0;
      for (k = 7; k >= 0; k = k - 1)
        if (v[k])
          enc = k[2:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and storage
  reg [31:0] ctrl_ff;
  reg [7:0]  sen_ff;
  reg [31:0] thr_ff;
  reg [31:0] noise_ff;
  reg [31:0] cnt_ff;
  reg [15:0] mtx_ff;
  reg [3:0]  ist_ff;
  reg [3:0]  imsk_ff;
  reg [3:0]  dsel_ff;
  reg [31:0] rdata_ff;
  reg        rd_ph_ff;
  reg        wr_ph_ff;
  reg [7:0]  addr_ff;
  reg [1:0]  st_ff;
  reg [3:0]  cur_ff;
  reg [7:0]  mask_ff;
  reg [15:0] cyc_ff;
  reg [15:0] acc_ff;
  reg        idac_ff;
  reg [15:0] raw_ff  [0:8];
  reg [15:0] base_ff [0:8];
  reg [15:0] diff_ff [0:8];
  reg [7:0]  deb_ff  [0:8];
  reg [7:0]  lbr_ff  [0:8];
  reg [8:0]  on_ff;
  reg [8:0]  init_ff;
  integer    i;

  wire        mod_s;
  wire        cfg_auto  = ctrl_ff[`TSSP_F_AUTO];
  wire [2:0]  guard_idx = ctrl_ff[6:4];
  wire [4:0]  res_n     = ctrl_ff[12:8];
  wire [3:0]  shamt     = ctrl_ff[15:12];
  wire [15:0] fth       = thr_ff[15:0];
  wire [15:0] hys       = {8'h00, thr_ff[23:16]};
  wire [15:0] nth       = noise_ff[15:0];
  wire [15:0] neg_nth   = noise_ff[31:16];
  wire [7:0]  deb_cfg   = cnt_ff[7:0];
  wire [7:0]  lbr_cfg   = cnt_ff[15:8];

  tssp_sync3 u_sync (
    .clk  (REF_CLK),
    .rst  (RST),
    .din  (MOD_BIT),
    .dout (mod_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Per-sensor arithmetic for the slot under processing
  wire [15:0] r   = acc_ff;
  wire [15:0] b   = base_ff[cur_ff];
  wire        up  = r > b;
  wire [15:0] r_b = r - b;
  wire [15:0] b_r = b - r;
  wire [15:0] dcount = (up && (r_b >= nth)) ? r_b : 16'h0000;
  wire        low    = (b > r) && (b_r > neg_nth);
  wire [16:0] thr_hi = {1'b0, fth} + {1'b0, hys};
  wire [15:0] thr_lo = (fth > hys) ? (fth - hys) : 16'h0000;
  wire [16:0] sdiff  = {1'b0, r} - {1'b0, b};
  wire [16:0] step   = $signed(sdiff) >>> shamt;
  wire [15:0] base_f = b + step[15:0];
  wire [7:0]  deb_set = (deb_cfg == 8'h00) ? 8'h01 : deb_cfg;
  wire [8:0]  deb_inc = {1'b0, deb_ff[cur_ff]} + 9'h001;
  wire [8:0]  lbr_inc = {1'b0, lbr_ff[cur_ff]} + 9'h001;
  // Scan length is 2^N-1; N above 16 saturates, N of zero runs one clock
  wire [16:0] len_w   = (res_n >= 5'h10) ? 17'h0ffff : ((17'h00001 << res_n) - 17'h00001);
  wire [15:0] scan_len = (len_w[15:0] == 16'h0000) ? 16'h0001 : len_w[15:0];
  wire        guard_lock = ctrl_ff[`TSSP_F_GUARD] && on_ff[guard_idx];
  wire        gang_go = ctrl_ff[`TSSP_F_GANG] && (on_ff == 9'h000);

  ////////////////////////////////////////////////////////////////////////////////
  // Matrix: single intersection only
  wire [7:0] rows   = on_ff[7:0] & mtx_ff[7:0];
  wire [7:0] cols   = on_ff[7:0] & mtx_ff[15:8];
  wire       mtx_ok = (popc(rows) == 4'h1) && (popc(cols) == 4'h1);
  wire [2:0] mtx_r  = mtx_ok ? enc(rows) : 3'h0;
  wire [2:0] mtx_c  = mtx_ok ? enc(cols) : 3'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Scan sequencer and per-sensor processing
  wire       hit_hi = init_ff[cur_ff] && ({1'b0, dcount} > thr_hi);
  reg  [3:0] ev;
  always @*
  begin
    ev[`TSSP_I_DONE]  = (st_ff == S_PROC);
    ev[`TSSP_I_CHG]   = (st_ff == S_PROC) && (hit_hi ? ((deb_inc >= {1'b0, deb_set}) && !on_ff[cur_ff]) :
                                                       ((dcount < thr_lo) && on_ff[cur_ff]));
    ev[`TSSP_I_LBR]   = (st_ff == S_PROC) && init_ff[cur_ff] && low && (lbr_inc > {1'b0, lbr_cfg});
    ev[`TSSP_I_GUARD] = (st_ff == S_IDLE) && ctrl_ff[`TSSP_F_EN] && guard_lock;
  end
  always @(posedge REF_CLK)
  begin
    if (RST)
    begin
      st_ff   <= S_IDLE;
      cur_ff  <= 4'h0;
      mask_ff <= 8'h00;
      cyc_ff  <= 16'h0000;
      acc_ff  <= 16'h0000;
      idac_ff <= 1'b0;
      on_ff   <= 9'h000;
      init_ff <= 9'h000;
      for (i = 0; i < 9; i = i + 1)
      begin
        raw_ff[i]  <= 16'h0000;
        base_ff[i] <= 16'h0000;
        diff_ff[i] <= 16'h0000;
        deb_ff[i]  <= 8'h00;
        lbr_ff[i]  <= 8'h00;
      end
    end
    else
    begin
      idac_ff <= (st_ff == S_SCAN) && mod_s;
      case (st_ff)
        S_IDLE:
        begin
          if (ctrl_ff[`TSSP_F_EN])
          begin
            // Guard lockout keeps only the guard sensor in the round
            mask_ff <= guard_lock ? (8'h01 << guard_idx) : sen_ff;
            if (gang_go && !guard_lock && (sen_ff != 8'h00))
            begin
              cur_ff <= `TSSP_GANG;
              cyc_ff <= 16'h0000;
              acc_ff <= 16'h0000;
              st_ff  <= S_SCAN;
            end
            else
            begin
              cur_ff <= 4'h0;
              st_ff  <= S_CHK;
            end
          end
        end
        S_CHK:
        begin
          if (cur_ff[3])
          begin
            // Round done: drop the ganged touch so idle rounds resume ganging
            on_ff[8]  <= 1'b0;
            deb_ff[8] <= 8'h00;
            st_ff     <= S_IDLE;
          end
          else if (mask_ff[cur_ff[2:0]])
          begin
            cyc_ff <= 16'h0000;
            acc_ff <= 16'h0000;
            st_ff  <= S_SCAN;
          end
          else
            cur_ff <= cur_ff + 4'h1;
        end
        S_SCAN:
        begin
          acc_ff <= acc_ff + {15'h0000, mod_s};
          cyc_ff <= cyc_ff + 16'h0001;
          if (cyc_ff + 16'h0001 == scan_len)
            st_ff <= S_PROC;
        end
        default:
        begin
          raw_ff[cur_ff]  <= r;
          diff_ff[cur_ff] <= dcount;
          if (!init_ff[cur_ff])
          begin
            // First scan seeds the baseline
            init_ff[cur_ff] <= 1'b1;
            base_ff[cur_ff] <= r;
            diff_ff[cur_ff] <= 16'h0000;
          end
          else if (low)
          begin
            if (lbr_inc > {1'b0, lbr_cfg})
            begin
              base_ff[cur_ff] <= r;
              lbr_ff[cur_ff]  <= 8'h00;
            end
            else
              lbr_ff[cur_ff] <= lbr_inc[7:0];
          end
          else
          begin
            lbr_ff[cur_ff] <= 8'h00;
            if (cfg_auto || (dcount == 16'h0000))
              base_ff[cur_ff] <= base_f;
          end
          if (hit_hi)
          begin
            if (deb_inc >= {1'b0, deb_set})
            begin
              deb_ff[cur_ff] <= deb_set;
              on_ff[cur_ff]  <= 1'b1;
            end
            else
              deb_ff[cur_ff] <= deb_inc[7:0];
          end
          else
          begin
            deb_ff[cur_ff] <= 8'h00;
            if (dcount < thr_lo)
              on_ff[cur_ff] <= 1'b0;
          end
          if (cur_ff == `TSSP_GANG)
            st_ff <= S_IDLE;
          else
          begin
            cur_ff <= cur_ff + 4'h1;
            st_ff  <= S_CHK;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes complete with no wait, reads take one wait state
  wire take = HSEL && HTRANS[1] && HREADY;

  always @(posedge REF_CLK)
  begin
    if (RST)
    begin
      rd_ph_ff <= 1'b0;
      wr_ph_ff <= 1'b0;
      addr_ff  <= 8'h00;
      rdata_ff <= 32'h0000_0000;
      ctrl_ff  <= `TSSP_CTRL_RST;
      sen_ff   <= `TSSP_SEN_RST;
      thr_ff   <= `TSSP_THR_RST;
      noise_ff <= `TSSP_NSE_RST;
      cnt_ff   <= `TSSP_CNT_RST;
      mtx_ff   <= 16'h0000;
      ist_ff   <= 4'h0;
      imsk_ff  <= 4'h0;
      dsel_ff  <= 4'h0;
    end
    else
    begin
      rd_ph_ff <= take && !HWRITE;
      wr_ph_ff <= take && HWRITE;
      if (take)
        addr_ff <= {HADDR[7:2], 2'b00};
      if (rd_ph_ff)
      begin
        case (addr_ff)
          `TSSP_A_CTRL:  rdata_ff <= {16'h0000, ctrl_ff[15:8], 1'b0, ctrl_ff[6:0]};
          `TSSP_A_SEN:   rdata_ff <= {24'h000000, sen_ff};
          `TSSP_A_THR:   rdata_ff <= {8'h00, thr_ff[23:0]};
          `TSSP_A_NOISE: rdata_ff <= noise_ff;
          `TSSP_A_CNT:   rdata_ff <= {16'h0000, cnt_ff[15:0]};
          `TSSP_A_MTX:   rdata_ff <= {16'h0000, mtx_ff};
          `TSSP_A_STAT:  rdata_ff <= {13'h0000, mtx_c, 1'b0, mtx_r, 1'b0, mtx_ok,
                                     on_ff[8], st_ff != S_IDLE, on_ff[7:0]};
          `TSSP_A_IST:   rdata_ff <= {28'h0000000, ist_ff};
          `TSSP_A_IMSK:  rdata_ff <= {28'h0000000, imsk_ff};
          `TSSP_A_DSEL:  rdata_ff <= {28'h0000000, dsel_ff};
          `TSSP_A_RAW:   rdata_ff <= {16'h0000, raw_ff[dsel_ff]};
          `TSSP_A_BASE:  rdata_ff <= {16'h0000, base_ff[dsel_ff]};
          `TSSP_A_DIFF:  rdata_ff <= {16'h0000, diff_ff[dsel_ff]};
          default:       rdata_ff <= 32'h0000_0000;
        endcase
      end
      // Hardware events win over a same-cycle write-one-to-clear
      if (wr_ph_ff && (addr_ff == `TSSP_A_IST))
        ist_ff <= (ist_ff & ~HWDATA[3:0]) | ev;
      else
        ist_ff <= ist_ff | ev;
      if (wr_ph_ff)
      begin
        case (addr_ff)
          `TSSP_A_CTRL:  ctrl_ff  <= {16'h0000, HWDATA[15:8], 1'b0, HWDATA[6:0]};
          `TSSP_A_SEN:   sen_ff   <= HWDATA[7:0];
          `TSSP_A_THR:   thr_ff   <= {8'h00, HWDATA[23:0]};
          `TSSP_A_NOISE: noise_ff <= HWDATA;
          `TSSP_A_CNT:   cnt_ff   <= {16'h0000, HWDATA[15:0]};
          `TSSP_A_MTX:   mtx_ff   <= HWDATA[15:0];
          `TSSP_A_IMSK:  imsk_ff  <= HWDATA[3:0];
          `TSSP_A_DSEL:  dsel_ff  <= (HWDATA[3:0] > 4'h8) ? 4'h8 : HWDATA[3:0];
          default:       dsel_ff  <= dsel_ff;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign HRDATA      = rdata_ff;
  assign HREADYOUT   = !rd_ph_ff;
  assign HRESP       = 1'b0;
  assign MOD_IDAC_ON = idac_ff;
  assign SCAN_ACTIVE = (st_ff == S_SCAN);
  // Ganged scans tie every enabled sensor to the shared analog sense bus
  assign SENSE_SEL   = (st_ff != S_SCAN) ? 8'h00 :
                       (cur_ff == `TSSP_GANG) ? sen_ff : (8'h01 << cur_ff[2:0]);
  assign SENSOR_ON   = on_ff[7:0];
  assign IRQ         = |(ist_ff & imsk_ff);

endmodule
`default_nettype wire

// ### verilog/tssp_map.vh
`ifndef TSSP_MAP_VH
`define TSSP_MAP_VH
// Register byte offsets
`define TSSP_A_CTRL   8'h00
`define TSSP_A_SEN    8'h04
`define TSSP_A_THR    8'h08
`define TSSP_A_NOISE  8'h0c
`define TSSP_A_CNT    8'h10
`define TSSP_A_MTX    8'h14
`define TSSP_A_STAT   8'h18
`define TSSP_A_IST    8'h1c
`define TSSP_A_IMSK   8'h20
`define TSSP_A_DSEL   8'h24
`define TSSP_A_RAW    8'h28
`define TSSP_A_BASE   8'h2c
`define TSSP_A_DIFF   8'h30
// Control fields
`define TSSP_F_EN     0
`define TSSP_F_AUTO   1
`define TSSP_F_GANG   2
`define TSSP_F_GUARD  3
// Reset values: resolution 8 bits, filter shift 2
`define TSSP_CTRL_RST 32'h0000_2800
`define TSSP_SEN_RST  8'hff
`define TSSP_THR_RST  32'h0005_0040
`define TSSP_NSE_RST  32'h0014_0014
`define TSSP_CNT_RST  32'h0000_0503
// Sensor slots; the last slot holds the ganged group
`define TSSP_NSENS    8
`define TSSP_GANG     4'h8
// Interrupt status bits
`define TSSP_I_DONE   0
`define TSSP_I_CHG    1
`define TSSP_I_LBR    2
`define TSSP_I_GUARD  3
`endif

// ### verilog/tssp_sync3.v
`timescale 1ns/1ns
`default_nettype none
module tssp_sync3 (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Asynchronous level in, filtered level out
  input  wire din,
  output wire dout
);

  reg [2:0] sh_ff;
  reg       out_ff;

  // Stage 0 feeds only stage 1; a change is taken once stages 1 and 2 agree
  always @(posedge clk)
  begin
    if (rst)
    begin
      sh_ff  <= 3'h0;
      out_ff <= 1'b0;
    end
    else
    begin
      sh_ff <= {sh_ff[1:0], din};
      if (sh_ff[1] == sh_ff[2])
        out_ff <= sh_ff[2];
    end
  end

  assign dout = out_ff;

endmodule
`default_nettype wire

// ### tb/tssp_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module tssp_chk (
  // Clock and reset
  input wire logic       REF_CLK,
  input wire logic       RST,
  // Bus handshake
  input wire logic       HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic       HWRITE,
  input wire logic       HREADY,
  input wire logic       HREADYOUT,
  // Sensing
  input wire logic       MOD_IDAC_ON,
  input wire logic [7:0] SENSE_SEL,
  input wire logic       SCAN_ACTIVE,
  input wire logic [7:0] SENSOR_ON
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  logic        acc;
  logic [16:0] run_ff;
  assign acc = HSEL && HTRANS[1] && HREADY && HREADYOUT;
  // Length of the running scan; any legal length is one short of a power of two
  always @(posedge REF_CLK)
    run_ff <= (RST || !SCAN_ACTIVE) ? 17'h0 : run_ff + 17'h1;
  ////////////////////////////////////////////////////////////////////////////
  rd_wait_a: assert property (acc && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read data phase not two cycles");
  wr_ready_a: assert property (acc && HWRITE |=> HREADYOUT)
    else $error("write data phase stalled");
  scan_len_a: assert property ($fell(SCAN_ACTIVE) |-> ((run_ff + 17'h1) & run_ff) == 17'h0)
    else $error("scan length wrong");
  sel_active_a: assert property ((SENSE_SEL != 8'h00) == SCAN_ACTIVE)
    else $error("sensor select outside scan");
  sel_hold_a: assert property (SCAN_ACTIVE && $past(SCAN_ACTIVE) |-> $stable(SENSE_SEL))
    else $error("sensor select moved in scan");
  scan_gap_a: assert property ($fell(SCAN_ACTIVE) |=> !SCAN_ACTIVE)
    else $error("no processing between scans");
  idac_gate_a: assert property (MOD_IDAC_ON |-> SCAN_ACTIVE || $past(SCAN_ACTIVE))
    else $error("modulation current outside scan");
  state_upd_a: assert property ($changed(SENSOR_ON) |-> !SCAN_ACTIVE && $past(SCAN_ACTIVE, 2))
    else $error("sensor state changed off processing");
endmodule
bind tssp_top tssp_chk tssp_chk_i (
  .REF_CLK, .RST, .HSEL, .HTRANS, .HWRITE, .HREADY, .HREADYOUT,
  .MOD_IDAC_ON, .SENSE_SEL, .SCAN_ACTIVE, .SENSOR_ON
);
`default_nettype wire

// ### tb/tssp_afe.sv
`timescale 1ns/1ns
`default_nettype none
module tssp_afe (
  // Clock
  input wire logic       clk,
  // Device side
  input wire logic [7:0] sense_sel,
  input wire logic       scan_active,
  // Sensors touched or pulled abnormally low
  input wire logic [7:0] touch,
  input wire logic [7:0] low,
  // Modulator bit
  output logic           mod_bit
);
  logic [3:0] ph_ff = 4'h0;
  // Phase restarts per scan so an untouched sensor always gives the same count
  always @(posedge clk)
    ph_ff <= scan_active ? ph_ff + 4'h1 : 4'h0;
  // Quiet between scans, so no touch level leaks into the next sensor
  always_comb
    if (!scan_active || (sense_sel & low) != 8'h00)
      mod_bit = 1'b0;
    else if ((sense_sel & touch) != 8'h00)
      mod_bit = 1'b1;
    else
      mod_bit = ph_ff[1];
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "tssp_map.vh"
module testbench;
  logic        REF_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0]  HTRANS = 2'h0;
  logic        HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [7:0]  touch = 8'h00;
  logic [7:0]  low = 8'h00;
  wire  [31:0] HRDATA;
  wire         HREADYOUT;
  wire         HRESP;
  wire         MOD_BIT;
  wire         MOD_IDAC_ON;
  wire  [7:0]  SENSE_SEL;
  wire         SCAN_ACTIVE;
  wire  [7:0]  SENSOR_ON;
  wire         IRQ;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          idac_cnt = 0;

  tssp_top tssp_top_i (
    .REF_CLK(REF_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .MOD_BIT(MOD_BIT), .MOD_IDAC_ON(MOD_IDAC_ON), .SENSE_SEL(SENSE_SEL),
    .SCAN_ACTIVE(SCAN_ACTIVE), .SENSOR_ON(SENSOR_ON), .IRQ(IRQ));
  tssp_afe tssp_afe_i (.clk(REF_CLK), .sense_sel(SENSE_SEL), .scan_active(SCAN_ACTIVE),
    .touch(touch), .low(low), .mod_bit(MOD_BIT));

  initial
    forever #4 REF_CLK = ~REF_CLK;
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic hang;
    bad_count++;
    complete_run;
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", w, e, g);
    end
  endtask
  // Ready is looked at before the edge, so the edge decides alone
  task automatic wait_ready(output logic [31:0] d);
    logic r;
    for (int n = 0; n < 50; n++)
    begin
      @(negedge REF_CLK);
      r = HREADYOUT;
      d = HRDATA;
      @(posedge REF_CLK);
      if (r === 1'b1)
        return;
    end
    hang;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    wait_ready(d);
    HTRANS <= 2'h0;
    HWDATA <= wd;
    wait_ready(d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
    @(posedge REF_CLK);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    bus(1'b0, a, 32'h0, x);
  endtask
  task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    rd(a, x);
    chk(w, e, x);
    chk("hresp", 0, HRESP);
  endtask
  // Waits for whole scans of one select pattern, counting scans of others
  task automatic scans(input logic [7:0] sel, input int times, output int others);
    int len;
    logic [7:0] last;
    int ic;
    len = -99;
    others = 0;
    ic = 0;
    for (int n = 0; n < 4000 && times > 0; n++)
    begin
      @(negedge REF_CLK);
      // Current pulses follow the scan state one clock late, so the first idle clock still counts
      ic = ic + (MOD_IDAC_ON === 1'b1);
      if (SCAN_ACTIVE === 1'b1)
      begin
        len++;
        last = SENSE_SEL;
      end
      else
      begin
        if (len > 0 && last === sel)
        begin
          times--;
          idac_cnt = ic;
          chk("scan length", 15, len);
        end
        else if (len > 0)
          others++;
        len = 0;
        ic = 0;
      end
    end
    if (times > 0)
      hang;
    repeat (2) @(posedge REF_CLK);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_touch;
    int o;
    logic [31:0] x;
    scans(8'h02, 2, o);
    chk("irq masked", 0, IRQ);
    wr(`TSSP_A_IMSK, 32'h2);
    wr(`TSSP_A_IST, 32'hf);
    chk("irq idle", 0, IRQ);
    touch <= 8'h02;
    scans(8'h02, 1, o);
    chk("on early", 0, SENSOR_ON);
    chk("idac pulses", 11, idac_cnt);
    rd(`TSSP_A_DIFF, x);
    chk("diff touched", 6, x);
    scans(8'h02, 1, o);
    chk("on", 8'h02, SENSOR_ON);
    chk("irq on", 1, IRQ);
    wr(`TSSP_A_IST, 32'h2);
    chk("irq cleared", 0, IRQ);
  endtask
  task automatic t_guard;
    int o;
    wr(`TSSP_A_CTRL, 32'h2419);
    scans(8'h02, 1, o);
    scans(8'h02, 2, o);
    chk("guard others", 0, o);
    wr(`TSSP_A_CTRL, 32'h2401);
  endtask
  task automatic t_release;
    int o;
    touch <= 8'h00;
    scans(8'h02, 2, o);
    chk("off", 0, SENSOR_ON);
    rdc("diff idle", `TSSP_A_DIFF, 32'h0);
  endtask
  task automatic t_gang;
    int o;
    wr(`TSSP_A_CTRL, 32'h2405);
    scans(8'h03, 1, o);
    scans(8'h03, 2, o);
    chk("gang others", 0, o);
    touch <= 8'h02;
    scans(8'h02, 1, o);
    touch <= 8'h00;
    wr(`TSSP_A_CTRL, 32'h2401);
    scans(8'h02, 2, o);
  endtask
  task automatic t_matrix;
    int o;
    logic [31:0] x;
    wr(`TSSP_A_MTX, 32'h0201);
    touch <= 8'h03;
    scans(8'h02, 2, o);
    chk("matrix on", 8'h03, SENSOR_ON);
    rd(`TSSP_A_STAT, x);
    chk("matrix one", 32'h0001_0403, x & 32'hffff_feff);
    wr(`TSSP_A_MTX, 32'h0003);
    rd(`TSSP_A_STAT, x);
    chk("matrix two rows", 32'h0000_0003, x & 32'hffff_feff);
    touch <= 8'h00;
    scans(8'h02, 2, o);
    chk("matrix off", 0, SENSOR_ON);
  endtask
  task automatic t_low;
    int o;
    logic [31:0] x;
    wr(`TSSP_A_IST, 32'hf);
    low <= 8'h02;
    scans(8'h02, 1, o);
    rd(`TSSP_A_IST, x);
    chk("lbr early", 0, x[2]);
    scans(8'h02, 1, o);
    rd(`TSSP_A_IST, x);
    chk("lbr", 1, x[2]);
    chk("idac low", 0, idac_cnt);
    rdc("base reload", `TSSP_A_BASE, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    rdc("ctrl", `TSSP_A_CTRL, `TSSP_CTRL_RST);
    rdc("thr", `TSSP_A_THR, `TSSP_THR_RST);
    rdc("hole", 8'h3c, 32'h0);
    wr(`TSSP_A_THR, 32'h0001_0003);
    wr(`TSSP_A_NOISE, 32'h0002_0002);
    wr(`TSSP_A_CNT, 32'h0000_0102);
    wr(`TSSP_A_SEN, 32'h3);
    wr(`TSSP_A_DSEL, 32'h1);
    wr(`TSSP_A_IMSK, 32'h0);
    wr(`TSSP_A_CTRL, 32'h2401);
    t_touch;
    t_guard;
    t_release;
    t_gang;
    t_matrix;
    t_low;
    complete_run;
  end
endmodule
`default_nettype wire
